// ==== hw/dct_host.sv ====
// The address map and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dct_host (
  input wire logic clk, // Clock, 20 MHz
  input wire logic rst, // Async reset, high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped
  output logic ch1TransmitInput, // Channel 1 transmit pin
  output logic ch1StandbySelect, // Channel 1 standby pin
  input wire logic ch1ReceiveOutput, // Channel 1 receive pin
  output logic ch2TransmitInput, // Channel 2 transmit pin
  output logic ch2StandbySelect, // Channel 2 standby pin
  input wire logic ch2ReceiveOutput // Channel 2 receive pin
);
  import dct_pkg::*;

  logic [7:0] ctrl_r;
  logic [BIT_PER_W-1:0] bitPer_r;
  logic [31:0] prdata_r;
  logic trip_r [NUM_CH];
  logic wake_r [NUM_CH];
  logic [CNT_W-1:0] edges_r [NUM_CH];
  logic stb_r [NUM_CH];

  dct_chan_if chIf [NUM_CH] ();

  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hitCtrl = (paddr == OFS_CTRL);
  wire hitBitPer = (paddr == OFS_BITPER);
  wire hitStatus = (paddr == OFS_STATUS);
  wire hitEdges0 = (paddr == OFS_EDGES0);
  wire hitEdges1 = (paddr == (OFS_EDGES0 + 12'h004));
  wire mapped = hitCtrl | hitBitPer | hitStatus | hitEdges0 | hitEdges1;
  wire wrEn = access & pwrite & mapped;
  wire wrCtrl = wrEn & hitCtrl;
  wire wrBitPer = wrEn & hitBitPer;
  wire wrStatus = wrEn & hitStatus;
  wire [NUM_CH-1:0] wrEdges = {wrEn & hitEdges1, wrEn & hitEdges0};

  // Clamp keeps the bit rate at or above the lowest rate the timeout allows
  wire [BIT_PER_W-1:0] wrPer = pwdata[BIT_PER_W-1:0];
  wire [BIT_PER_W-1:0] perClamped = (wrPer > BIT_PER_MAX) ? BIT_PER_MAX :
                                    (wrPer < BIT_PER_MIN) ? BIT_PER_MIN : wrPer; // [RL9]

  wire [31:0] statusWord;
  assign statusWord[31:NUM_CH*CH_FIELD_W] = '0;

  wire [31:0] rdValue = hitCtrl ? {24'h0, ctrl_r} :
                        hitBitPer ? {20'h0, bitPer_r} :
                        hitStatus ? statusWord :
                        hitEdges0 ? {16'h0, edges_r[0]} :
                        hitEdges1 ? {16'h0, edges_r[1]} : 32'h0;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= CTRL_RST; // [RL17] [RL16]
      bitPer_r <= BIT_PER_RST;
      prdata_r <= 32'h0;
    end else begin
      if (wrCtrl) begin
        ctrl_r <= pwdata[7:0] & CTRL_MASK;
      end
      if (wrBitPer) begin
        bitPer_r <= perClamped;
      end
      if (setup && !pwrite) begin
        prdata_r <= rdValue;
      end
    end
  end

  wire [NUM_CH-1:0] rxPins = {ch2ReceiveOutput, ch1ReceiveOutput};
  wire [NUM_CH-1:0] txPins;
  wire [NUM_CH-1:0] stbPins;

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : gCh
      wire stbReq = ctrl_r[i*CH_FIELD_W+CTRL_STB];
      wire txReq = ctrl_r[i*CH_FIELD_W+CTRL_TX];
      wire clrTrip = wrStatus & pwdata[i*CH_FIELD_W+STAT_TRIP];
      wire clrWake = wrStatus & pwdata[i*CH_FIELD_W+STAT_WAKE];
      // Wake only counts while the pin selects standby
      wire wakeSet = chIf[i].fallPulse & stb_r[i]; // [RL20]
      wire [CNT_W-1:0] edgeInc = {{(CNT_W-1){1'b0}}, chIf[i].fallPulse};

      // Guard sees the requested mode, so transmit and standby pins move together
      assign chIf[i].standby = stbReq; // [RL19]
      assign chIf[i].txReq = txReq;
      assign chIf[i].bitPer = bitPer_r;
      assign chIf[i].rxPin = rxPins[i];

      dct_guard uGuard (
        .clk(clk),
        .rst(rst),
        .ch(chIf[i])
      );

      dct_rx_mon uRxMon (
        .clk(clk),
        .rst(rst),
        .ch(chIf[i])
      );

      // Setting wins over a clear arriving in the same cycle
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          stb_r[i] <= 1'b1; // [RL17]
          trip_r[i] <= 1'b0;
          wake_r[i] <= 1'b0;
          edges_r[i] <= {CNT_W{1'b0}};
        end else begin
          stb_r[i] <= stbReq; // [RL19] [RL18]
          trip_r[i] <= chIf[i].tripPulse | (trip_r[i] & ~clrTrip);
          wake_r[i] <= wakeSet | (wake_r[i] & ~clrWake);
          edges_r[i] <= wrEdges[i] ? edgeInc : edges_r[i] + edgeInc;
        end
      end

      assign statusWord[i*CH_FIELD_W +: CH_FIELD_W] =
        {chIf[i].txPin, wake_r[i], trip_r[i], chIf[i].rxLevel};
      assign txPins[i] = chIf[i].txPin;
      assign stbPins[i] = stb_r[i];
    end
  endgenerate

  assign ch1TransmitInput = txPins[0];
  assign ch2TransmitInput = txPins[1];
  assign ch1StandbySelect = stbPins[0];
  assign ch2StandbySelect = stbPins[1];
  assign prdata = prdata_r;
  assign pready = access;
  assign pslverr = access & ~mapped;
endmodule
`default_nettype wire

// ==== hw/dct_pkg.sv ====
// Operation
// (RL1) Low transmit requests dominant; low receive means dominant
// (RL2) High transmit leaves bus recessive; high receive
// (RL3) Receive shows dominant from any node
// (RL4) Standby lets bus lines drift to ground
// (RL5) Normal mode: falling transmit starts timeout timer
// (RL6) Long dominant transmit disables driver after 1.2 ms
// (RL7) Recessive transmit clears timeout, re-enables driver
// (RL8) Receiver keeps working during dominant timeout
// (RL9) Controller holds dominant at most 11 bits
// (RL10) Thermal fault disables driver, blocks transmit path
// (RL11) Thermal fault clears with hysteresis
// (RL12) Thermal fault keeps bias and receive path
// (RL13) Undervoltage floats bus and receive output
// (RL14) Either supply low triggers undervoltage protection
// (RL15) After undervoltage, wait settling time before normal
// (RL16) Floating transmit input defaults to recessive
// (RL17) Floating standby select defaults to standby
// (RL18) Standby select may be held low permanently
// (RL19) High standby select is standby; low normal
// (RL20) Standby stops driver and receiver, monitor only
// (RL21) Driver enabled only when normal and fault-free
package dct_pkg;
  localparam int NUM_CH = 2;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  localparam int DTO_MIN_NS = 1_200_000;
  localparam int MIN_RATE_BPS = 9200;
  localparam int BIT_PER_W = 12;
  localparam int CNT_W = 16;
  // Bit period at the 9200 bps minimum rate, which keeps 11 dominant bits under the timeout
  localparam logic [BIT_PER_W-1:0] BIT_PER_MAX = BIT_PER_W'(CLK_HZ / MIN_RATE_BPS);
  localparam logic [BIT_PER_W-1:0] BIT_PER_MIN = 12'h001;
  localparam logic [BIT_PER_W-1:0] BIT_PER_RST = 12'h028;
  localparam logic [CNT_W-1:0] MAX_DOM_BITS = 16'h000b;
  localparam logic [CNT_W-1:0] DTO_MIN_CYC = CNT_W'(DTO_MIN_NS / CLK_PERIOD_NS);

  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_BITPER = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_EDGES0 = 12'h00c;
  localparam int CH_FIELD_W = 4;
  localparam int CTRL_STB = 0;
  localparam int CTRL_TX = 1;
  localparam int STAT_RX = 0;
  localparam int STAT_TRIP = 1;
  localparam int STAT_WAKE = 2;
  localparam int STAT_TXPIN = 3;
  localparam logic [7:0] CTRL_MASK = 8'h33;
  localparam logic [7:0] CTRL_RST = 8'h33;

  typedef enum logic [1:0] {
    DCT_GD_IDLE = 2'b00,
    DCT_GD_COUNT = 2'b01,
    DCT_GD_TRIP = 2'b10
  } dct_guard_t;
endpackage

// ==== hw/dct_chan_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface dct_chan_if;
  import dct_pkg::*;
  logic standby;
  logic txReq;
  logic [BIT_PER_W-1:0] bitPer;
  logic txPin;
  logic tripPulse;
  logic tripActive;
  logic rxPin;
  logic rxLevel;
  logic fallPulse;
  modport guard (input standby, input txReq, input bitPer,
                 output txPin, output tripPulse, output tripActive);
  modport mon (input rxPin, output rxLevel, output fallPulse);
endinterface
`default_nettype wire

// ==== hw/dct_guard.sv ====
`timescale 1ns/1ps
`default_nettype none
module dct_guard (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset, high
  dct_chan_if.guard ch // Channel signals
);
  import dct_pkg::*;
  dct_guard_t state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic txPin_r, txPin_nxt;
  logic trip_r, trip_nxt;
  wire [CNT_W-1:0] limit = CNT_W'({4'h0, ch.bitPer} * MAX_DOM_BITS);
  wire release_w = ch.standby | ch.txReq;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    trip_nxt = 1'b0;
    case (state_r)
      DCT_GD_IDLE: begin
        cnt_nxt = {CNT_W{1'b0}};
        if (!release_w) begin
          state_nxt = DCT_GD_COUNT;
          cnt_nxt = 16'h0001;
        end
      end
      DCT_GD_COUNT: begin
        // Cut dominant at 11 bit times, before the device timeout
        if (release_w) begin
          state_nxt = DCT_GD_IDLE;
        end else if (cnt_r >= limit) begin // [RL9] [RL6]
          state_nxt = DCT_GD_TRIP;
          trip_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      DCT_GD_TRIP: begin
        if (release_w) begin
          state_nxt = DCT_GD_IDLE;
        end
      end
      default: state_nxt = DCT_GD_IDLE;
    endcase
    // Standby leaves transmit recessive; low drives dominant [RL1] [RL2] [RL20]
    txPin_nxt = release_w | (state_nxt == DCT_GD_TRIP);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= DCT_GD_IDLE;
      cnt_r <= {CNT_W{1'b0}};
      txPin_r <= 1'b1; // [RL16]
      trip_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      txPin_r <= txPin_nxt;
      trip_r <= trip_nxt;
    end
  end

  assign ch.txPin = txPin_r;
  assign ch.tripPulse = trip_r;
  assign ch.tripActive = (state_r == DCT_GD_TRIP);
endmodule
`default_nettype wire

// ==== hw/dct_rx_mon.sv ====
`timescale 1ns/1ps
`default_nettype none
module dct_rx_mon (
  input wire logic clk, // Clock
  input wire logic rst, // Async reset, high
  dct_chan_if.mon ch // Channel signals
);
  import dct_pkg::*;
  logic rxLevel_r;
  logic fall_r;
  // Idle bus reads recessive, so reset to high avoids a false edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rxLevel_r <= 1'b1;
      fall_r <= 1'b0;
    end else begin
      rxLevel_r <= ch.rxPin; // [RL3]
      fall_r <= rxLevel_r & ~ch.rxPin; // [RL1]
    end
  end
  assign ch.rxLevel = rxLevel_r;
  assign ch.fallPulse = fall_r;
endmodule
`default_nettype wire

// ==== hw/dct_end.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== bench/dct_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module dct_dev_model
  import dct_pkg::*;
#(
  parameter int DTO_CYC = int'(DTO_MIN_CYC), // Dominant timeout in clocks
  parameter int SETTLE_CYC = 8 // Mode settling after supply recovery
) (
  input wire logic clk, // Clock for the timers
  input wire logic rst, // Reset, high
  input wire logic tx1, // Ch1 transmit
  input wire logic ch1_standby_select, // Ch1 standby
  input wire logic tx2, // Ch2 transmit
  input wire logic ch2_standby_select, // Ch2 standby
  input wire logic dom1, // Other node dominant, ch1
  input wire logic dom2, // Other node dominant, ch2
  input wire logic [1:0] hot, // Over temperature, per channel
  input wire logic lowVio, // Shared logic supply low
  input wire logic [1:0] lowVcc, // Channel supply low
  output wire logic rx1, // Ch1 receive, floats when protected
  output wire logic rx2, // Ch2 receive, floats when protected
  output wire logic [1:0] busDom, // Bus dominant, per channel
  output wire logic [1:0] bias // Bus biased to mid-supply
);
  wire [1:0] tx = {tx2, tx1};
  wire [1:0] stb = {ch2_standby_select, ch1_standby_select};
  wire [1:0] dom = {dom2, dom1};
  wire [1:0] rxBit;
  wire [1:0] prot;
  genvar i;
  for (i = 0; i < 2; i++) begin : gCh
    int dtoCnt;
    int settleCnt;
    wire uvNow = lowVio | lowVcc[i];
    wire dtoOn = dtoCnt > DTO_CYC;
    // Hysteresis lives in the temperature indication itself
    wire drvEn = ~stb[i] & ~dtoOn & ~hot[i] & ~prot[i];
    always @(posedge clk or posedge rst) begin
      if (rst) begin
        dtoCnt <= 0;
        settleCnt <= 0;
      end else begin
        // Falling transmit starts the timer, recessive stops and clears it
        if (stb[i] || tx[i] || prot[i]) dtoCnt <= 0;
        else if (!dtoOn) dtoCnt <= dtoCnt + 1;
        if (uvNow) settleCnt <= SETTLE_CYC;
        else if (settleCnt != 0) settleCnt <= settleCnt - 1;
      end
    end
    assign prot[i] = uvNow | (settleCnt != 0);
    assign busDom[i] = (drvEn & ~tx[i]) | dom[i];
    // Standby pulls to ground; timeout and heat keep the bias
    assign bias[i] = ~stb[i] & ~prot[i];
    // No wake pattern is modelled, so standby reads recessive
    assign rxBit[i] = stb[i] | ~busDom[i];
  end
  assign rx1 = prot[0] ? 1'bz : rxBit[0];
  assign rx2 = prot[1] ? 1'bz : rxBit[1];
endmodule
`default_nettype wire

// ==== bench/dct_host_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module dct_host_assertions
  import dct_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic psel, // APB
  input wire logic penable, // APB
  input wire logic pwrite, // APB
  input wire logic [11:0] paddr, // APB
  input wire logic [31:0] pwdata, // APB
  input wire logic pready, // APB
  input wire logic pslverr, // APB
  input wire logic ch1TransmitInput, // Pin
  input wire logic ch1StandbySelect, // Pin
  input wire logic ch2TransmitInput, // Pin
  input wire logic ch2StandbySelect // Pin
);
  logic [15:0] lowCnt;
  logic wrCtrl;
  assign wrCtrl = psel && penable && pwrite && paddr == OFS_CTRL;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) lowCnt <= 16'h0000;
    else lowCnt <= ch1TransmitInput ? 16'h0000 : lowCnt + 16'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ready_access_a: assert property (pready == (psel && penable))
    else $error("pready not tied to access");
  err_access_a: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  stby_quiet1_a: assert property (ch1StandbySelect |-> ch1TransmitInput)
    else $error("ch1 transmits in standby");
  stby_quiet2_a: assert property (ch2StandbySelect |-> ch2TransmitInput)
    else $error("ch2 transmits in standby");
  ctrl_pins1_a: assert property (wrCtrl |-> ##2 ch1StandbySelect == $past(pwdata[0], 2)
    && ch1TransmitInput == ($past(pwdata[1], 2) | $past(pwdata[0], 2)))
    else $error("ch1 pins miss CTRL write");
  ctrl_pins2_a: assert property (wrCtrl |-> ##2 ch2StandbySelect == $past(pwdata[4], 2)
    && ch2TransmitInput == ($past(pwdata[5], 2) | $past(pwdata[4], 2)))
    else $error("ch2 pins miss CTRL write");
  reset_pins_a: assert property ($fell(rst) |-> ch1TransmitInput && ch1StandbySelect
    && ch2TransmitInput && ch2StandbySelect)
    else $error("pins not idle at reset");
  dom_bound_a: assert property (lowCnt < DTO_MIN_CYC)
    else $error("dominant held too long");
endmodule
bind dct_host dct_host_assertions u_dct_host_assertions (.*);
`default_nettype wire

// ==== bench/dct_host_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module dct_host_tb;
  import dct_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, tx1, ch1_standby_select, tx2, ch2_standby_select, dom1 = 0, dom2 = 0, lowVio = 0;
  logic [1:0] hot = 0, lowVcc = 0, busDom, bias;
  tri1 rx1, rx2; // Board pull-ups hold receive high while the device floats it
  int err_count = 0, checks = 0, cyc = 0;
  always #25 clk = ~clk;
  dct_host u_dct_host (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ch1TransmitInput(tx1), .ch1StandbySelect(ch1_standby_select),
    .ch1ReceiveOutput(rx1), .ch2TransmitInput(tx2), .ch2StandbySelect(ch2_standby_select),
    .ch2ReceiveOutput(rx2));
  dct_dev_model u_dct_dev_model (.clk(clk), .rst(rst), .tx1(tx1), .ch1_standby_select(ch1_standby_select), .tx2(tx2),
    .ch2_standby_select(ch2_standby_select), .dom1(dom1), .dom2(dom2), .hot(hot), .lowVio(lowVio), .lowVcc(lowVcc),
    .rx1(rx1), .rx2(rx2), .busDom(busDom), .bias(bias));
  task close_out;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      close_out;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task t_reset;
    chk({tx1, ch1_standby_select, tx2, ch2_standby_select}, 4'hf);
    apb(0, OFS_CTRL, 0); chk(rd, 32'h33);
    apb(0, OFS_BITPER, 0); chk(rd, 32'h28);
    $display("reset test done");
  endtask
  task t_normal;
    apb(1, OFS_CTRL, 32'h22);
    repeat (3) @(posedge clk);
    chk({tx1, ch1_standby_select, tx2, ch2_standby_select}, 4'ha);
    apb(0, OFS_STATUS, 0); chk(rd & 32'h99, 32'h99);
    dom1 <= 1;
    repeat (3) @(posedge clk);
    apb(0, OFS_STATUS, 0); chk(rd & 32'h99, 32'h98);
    apb(0, OFS_EDGES0, 0); chk(rd, 32'h1);
    dom1 <= 0;
    $display("normal test done");
  endtask
  task t_guard;
    apb(1, OFS_BITPER, 2);
    apb(1, OFS_CTRL, 32'h20);
    repeat (22) @(posedge clk);
    chk(tx1, 0);
    repeat (2) @(posedge clk);
    chk(tx1, 1);
    apb(0, OFS_STATUS, 0); chk(rd[1], 1);
    apb(1, OFS_CTRL, 32'h22);
    apb(1, OFS_STATUS, 32'h2);
    apb(0, OFS_STATUS, 0); chk(rd[1], 0);
    $display("guard test done");
  endtask
  task t_fault;
    apb(1, OFS_BITPER, 32'h28);
    hot <= 2'b01;
    apb(1, OFS_CTRL, 32'h20);
    repeat (3) @(posedge clk);
    chk(busDom, 2'b00);
    apb(0, OFS_STATUS, 0); chk(rd[3:0], 4'h1);
    hot <= 2'b00;
    repeat (3) @(posedge clk);
    chk(busDom, 2'b01);
    apb(0, OFS_STATUS, 0); chk(rd[3:0], 4'h0);
    apb(1, OFS_CTRL, 32'h22);
    dom1 <= 1; dom2 <= 1; lowVio <= 1;
    repeat (3) @(posedge clk);
    apb(0, OFS_STATUS, 0); chk(rd & 32'h11, 32'h11);
    lowVio <= 0; lowVcc <= 2'b10;
    apb(0, OFS_STATUS, 0); chk(rd & 32'h11, 32'h11);
    repeat (12) @(posedge clk);
    apb(0, OFS_STATUS, 0); chk(rd & 32'h11, 32'h10);
    chk(bias, 2'b01);
    lowVcc <= 2'b00; dom1 <= 0; dom2 <= 0;
    $display("fault test done");
  endtask
  task t_stby;
    apb(1, OFS_CTRL, 32'h11);
    repeat (3) @(posedge clk);
    dom2 <= 1;
    chk({tx1, ch1_standby_select, tx2, ch2_standby_select}, 4'hf);
    chk(bias, 2'b00);
    apb(0, OFS_STATUS, 0); chk(rd[7:4], 4'h9);
    dom2 <= 0;
    apb(1, 12'hff0, 32'h0);
    chk(er, 1);
    apb(0, 12'hff0, 0); chk(er, 1);
    chk(rd, 0);
    apb(0, OFS_CTRL, 0); chk(rd, 32'h11);
    $display("standby test done");
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    t_reset;
    t_normal;
    t_guard;
    t_fault;
    t_stby;
    close_out;
  end
endmodule
`default_nettype wire
